// *** pkg/spi_frame_pkg.sv ***
// package: frame layout, crc and timing constants for the spi frame slave
package spi_frame_pkg;
    localparam int FRAME_BITS   = 32;
    localparam int CRC_BITS     = 3;
    localparam int ADDR_BITS    = 7;
    localparam int DATA_BITS    = 20;
    localparam int CHANNELS     = 6;
    localparam int CNT_BITS     = 6;
    // input frame fields
    localparam int IN_WR_POS    = 31;
    localparam int IN_ADDR_LSB  = 24;
    localparam int IN_RSV_POS   = 23;
    localparam int DATA_LSB     = 3;
    // output frame fields
    localparam int OUT_SHORT_POS = 31;
    localparam int OUT_LONG_POS  = 30;
    localparam int OUT_CRC_POS   = 29;
    localparam int OUT_EXC_LSB   = 23;
    // crc generator x^3+x+1 without the top term, zero seed
    localparam logic [2:0] CRC_POLY = 3'h3;
    localparam logic [2:0] CRC_SEED = 3'h0;
    localparam logic [5:0] CNT_FULL = 6'h20;
    localparam logic [5:0] CNT_ZERO = 6'h00;
    // commit delay after frame end, in clock cycles
    localparam int COMMIT_CYCLES = 1;

    typedef struct packed {
        logic                 write;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } req_t;

    typedef struct packed {
        logic shortFrame;
        logic longFrame;
        logic crcBad;
    } frame_err_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_FRAME  = 3'b010,
        ST_COMMIT = 3'b100
    } state_t;

    function automatic logic [2:0] crcStep(input logic [2:0] c, input logic b);
        logic fb;
        fb = c[2] ^ b;
        crcStep = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
    endfunction
endpackage

// *** rtl/fault_latch.sv ***
// per-channel exception recorder with read blanking and clear
`timescale 1ns/1ps
module fault_latch #(
    parameter int N = 6
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [N-1:0] faultIn,
    input  wire logic [N-1:0] readBusy,
    input  wire logic [N-1:0] clearPulse,
    output logic [N-1:0]      recorded
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            wire setOk = faultIn[i] & ~readBusy[i];
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    recorded[i] <= 1'b0;
                end else if (setOk) begin
                    recorded[i] <= 1'b1;
                end else if (clearPulse[i]) begin
                    recorded[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// *** rtl/spi_crc_frame_slave.sv ***
// spi target frame engine with crc, in-frame read data and error flags
`timescale 1ns/1ps
// Notes on behaviour
// - frames are exactly 32 bits, crc last three
// - read data returned within the same frame
// - crc uses polynomial x^3+x+1
// - bad crc frame: no write, no clear
// - crc and length errors reported next frame
// - six exception bits, OR per channel
// - details read and cleared via channel registers
// - fault during own read blanked, latched after read only if still present
// - input layout: flag, address, reserved, data, crc
// - output layout: errors, exceptions, data, crc
// - unused output data bits are zero
module spi_crc_frame_slave #(
    parameter int CH = spi_frame_pkg::CHANNELS
) (
    input  wire logic                                clk,
    input  wire logic                                resetn,
    input  wire logic                                sclk,
    input  wire logic                                csN,
    input  wire logic                                sdi,
    output logic                                     sdo,
    output logic                                     sdoOe,
    output spi_frame_pkg::req_t                      reqOut,
    output logic                                     reqValid,
    output logic [spi_frame_pkg::ADDR_BITS-1:0]      rdAddr,
    output logic                                     rdActive,
    input  wire logic [spi_frame_pkg::DATA_BITS-1:0] rdData,
    input  wire logic [CH-1:0]                       faultIn,
    input  wire logic [CH-1:0]                       faultRegRead,
    output logic [CH-1:0]                            excRecorded
);
    // pin synchronisers
    logic [1:0] sclkS_r, csS_r, sdiS_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclkS_r <= 2'h0;
            csS_r   <= 2'h3;
            sdiS_r  <= 2'h0;
        end else begin
            sclkS_r <= {sclkS_r[0], sclk};
            csS_r   <= {csS_r[0], csN};
            sdiS_r  <= {sdiS_r[0], sdi};
        end
    end
    logic sclkD_r, csD_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclkD_r <= 1'b0;
            csD_r   <= 1'b1;
        end else begin
            sclkD_r <= sclkS_r[1];
            csD_r   <= csS_r[1];
        end
    end
    wire sclkRise = sclkS_r[1] & ~sclkD_r;
    wire sclkFall = ~sclkS_r[1] & sclkD_r;
    wire csFall   = ~csS_r[1] & csD_r;
    wire csRise   = csS_r[1] & ~csD_r;
    wire csLow    = ~csS_r[1];

    spi_frame_pkg::state_t state_r, state_nxt;
    logic [31:0] rxSh_r;
    logic [31:0] txSh_r;
    logic [5:0]  bitCnt_r;
    logic [2:0]  rxCrc_r, txCrc_r;
    logic        overflow_r;
    spi_frame_pkg::frame_err_t err_r;
    logic [2:0]  commitCnt_r;
    logic        frameOk_r;

    // frame header seen after the first 8 bits: launch read early
    wire         hdrDone  = sclkRise && csLow && (bitCnt_r == 6'h07);
    wire [6:0]   hdrAddr  = {rxSh_r[5:0], sdiS_r[1]};
    wire         hdrWrite = rxSh_r[6];

    // assembled output frame head
    wire [8:0] headOut = {err_r.shortFrame, err_r.longFrame, err_r.crcBad,
                          excRecorded};
    wire [31:0] txLoad = {headOut, 23'h0};
    wire [19:0] txData = rdActive ? rdData : 20'h0;
    wire [2:0]  txCrcNxt = spi_frame_pkg::crcStep(txCrc_r, txSh_r[31]);

    // end of frame checks
    wire lenShort = bitCnt_r < spi_frame_pkg::CNT_FULL;
    wire crcBad   = rxCrc_r != rxSh_r[2:0];
    wire rsvBad   = rxSh_r[spi_frame_pkg::IN_RSV_POS];
    wire frameOk  = !lenShort && !overflow_r && !crcBad && !rsvBad;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            spi_frame_pkg::ST_IDLE:   if (csFall) state_nxt = spi_frame_pkg::ST_FRAME;
            spi_frame_pkg::ST_FRAME:  if (csRise) state_nxt = spi_frame_pkg::ST_COMMIT;
            spi_frame_pkg::ST_COMMIT: if (commitCnt_r == 3'(spi_frame_pkg::COMMIT_CYCLES))
                                          state_nxt = spi_frame_pkg::ST_IDLE;
            default:                  state_nxt = spi_frame_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= spi_frame_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // receive path and crc
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxSh_r     <= 32'h0;
            bitCnt_r   <= spi_frame_pkg::CNT_ZERO;
            rxCrc_r    <= spi_frame_pkg::CRC_SEED;
            overflow_r <= 1'b0;
        end else if (csFall) begin
            bitCnt_r   <= spi_frame_pkg::CNT_ZERO;
            rxCrc_r    <= spi_frame_pkg::CRC_SEED;
            overflow_r <= 1'b0;
        end else if (sclkRise && csLow) begin
            rxSh_r <= {rxSh_r[30:0], sdiS_r[1]};
            if (bitCnt_r == spi_frame_pkg::CNT_FULL) begin
                overflow_r <= 1'b1;
            end else begin
                bitCnt_r <= bitCnt_r + 6'h01;
            end
            if (bitCnt_r < 6'h1D) begin
                rxCrc_r <= spi_frame_pkg::crcStep(rxCrc_r, sdiS_r[1]);
            end
        end
    end

    // transmit path: head loaded at frame start, data at bit 9
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txSh_r  <= 32'h0;
            txCrc_r <= spi_frame_pkg::CRC_SEED;
            sdo     <= 1'b0;
            sdoOe   <= 1'b0;
        end else if (csFall) begin
            txSh_r  <= txLoad;
            txCrc_r <= spi_frame_pkg::CRC_SEED;
            sdo     <= txLoad[31];
            sdoOe   <= 1'b1;
        end else if (!csLow) begin
            sdoOe <= 1'b0;
            sdo   <= 1'b0;
        end else if (sclkFall && bitCnt_r != spi_frame_pkg::CNT_ZERO) begin
            if (bitCnt_r < 6'h1D) begin
                txCrc_r <= txCrcNxt;
            end
            if (bitCnt_r == 6'h09) begin
                txSh_r <= {txData, 12'h0};
                sdo    <= txData[19];
            end else if (bitCnt_r == 6'h1D) begin
                // crc must already hold bit 3, leaving on this edge
                txSh_r <= {txCrcNxt, 29'h0};
                sdo    <= txCrcNxt[2];
            end else begin
                txSh_r <= txSh_r << 1;
                sdo    <= txSh_r[30];
            end
        end
    end

    // read launch, error capture and delayed commit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdAddr      <= 7'h0;
            rdActive    <= 1'b0;
            err_r       <= '0;
            reqOut      <= '0;
            reqValid    <= 1'b0;
            commitCnt_r <= 3'h0;
        end else begin
            reqValid <= 1'b0;
            if (hdrDone && !hdrWrite) begin
                rdAddr   <= hdrAddr;
                rdActive <= 1'b1;
            end
            if (csRise && state_r == spi_frame_pkg::ST_FRAME) begin
                err_r.shortFrame <= lenShort;
                err_r.longFrame  <= overflow_r;
                err_r.crcBad     <= crcBad;
                reqOut.write <= rxSh_r[spi_frame_pkg::IN_WR_POS];
                reqOut.addr  <= rxSh_r[30:24];
                reqOut.data  <= rxSh_r[22:3];
                commitCnt_r  <= 3'h0;
            end
            if (state_r == spi_frame_pkg::ST_COMMIT) begin
                commitCnt_r <= commitCnt_r + 3'h1;
                if (commitCnt_r == 3'(spi_frame_pkg::COMMIT_CYCLES)) begin
                    reqValid <= frameOk_r;
                    rdActive <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frameOk_r <= 1'b0;
        end else if (csRise) begin
            frameOk_r <= frameOk;
        end
    end

    // clear only on a valid read of the channel fault register
    wire [CH-1:0] clearReq = (reqValid && !reqOut.write) ? faultRegRead : '0;
    logic [CH-1:0] recordedW;
    fault_latch #(.N(CH)) u_latch (
        .clk        (clk),
        .resetn     (resetn),
        .faultIn    (faultIn),
        .readBusy   (faultRegRead & {CH{rdActive}}),
        .clearPulse (clearReq),
        .recorded   (recordedW)
    );
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            excRecorded <= '0;
        end else begin
            excRecorded <= recordedW;
        end
    end
endmodule

// *** tb/spi_crc_frame_slave_props.sv ***
// port assertions for the spi frame slave
`timescale 1ns/1ps
module spi_crc_frame_slave_props #(
    parameter int CH = 6
) (
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                csN,
    input wire logic                sdoOe,
    input wire spi_frame_pkg::req_t reqOut,
    input wire logic                reqValid,
    input wire logic                rdActive,
    input wire logic [CH-1:0]       faultIn,
    input wire logic [CH-1:0]       faultRegRead,
    input wire logic [CH-1:0]       excRecorded
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_OE_OFF: assert property (csN [*4] |-> !sdoOe)
        else $error("sdo driven outside frame");
    AST_OE_ON: assert property (!csN [*4] |-> sdoOe)
        else $error("sdo not driven in frame");
    AST_VALID_ONE: assert property (reqValid |=> !reqValid)
        else $error("commit pulse too long");
    AST_VALID_LATE: assert property (reqValid |-> $past(csN, 2) && $past(csN, 3))
        else $error("commit too early after frame end");
    AST_RD_IDLE: assert property (csN [*8] |-> !rdActive)
        else $error("read active between frames");
    AST_REQ_HOLD: assert property (!csN [*5] |-> $stable(reqOut))
        else $error("request changed inside frame");
    AST_NO_LATCH: assert property ((rdActive && faultRegRead[1]) [*3] |-> !$rose(excRecorded[1]))
        else $error("fault latched during own read");
    AST_LATCH: assert property ((faultIn[1] && !rdActive) [*2] |=> excRecorded[1])
        else $error("fault not recorded");
endmodule
bind spi_crc_frame_slave spi_crc_frame_slave_props #(.CH(CH)) u_props (
    .clk(clk), .resetn(resetn), .csN(csN), .sdoOe(sdoOe), .reqOut(reqOut),
    .reqValid(reqValid), .rdActive(rdActive), .faultIn(faultIn),
    .faultRegRead(faultRegRead), .excRecorded(excRecorded));

// *** tb/spi_master_model.sv ***
// spi master model sending frames to the slave
`timescale 1ns/1ps
module spi_master_model (
    output logic     sclk,
    output logic     csN,
    output logic     sdi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end
    function automatic logic [2:0] crc3(input logic [31:0] f);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 31; i >= 3; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ f[i]) ? 3'h3 : 3'h0);
        return c;
    endfunction
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        csN = 1'b0;
        #800;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 32) ? tx[31-i] : 1'b0;
            #400 sclk = 1'b1;
            rx = {rx[30:0], miso};
            #400 sclk = 1'b0;
        end
        #100 csN = 1'b1;
        sdi = 1'b0;
        #1000;
    endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the spi frame slave
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic                clk = 1'b0;
    logic                resetn = 1'b0;
    logic                sclk, csN, sdi, sdo, sdoOe, reqValid, rdActive;
    spi_frame_pkg::req_t reqOut;
    logic [6:0]          rdAddr;
    logic [19:0]         rdData;
    logic [5:0]          faultIn, faultRegRead, excRecorded;
    logic [31:0]         rx;
    wire                 miso = sdoOe ? sdo : 1'bz;
    int                  n_fail = 0, checks_done = 0, nValid = 0;
    always #50 clk = ~clk;
    always @(posedge clk) if (reqValid === 1'b1) nValid++;
    spi_master_model m (.sclk(sclk), .csN(csN), .sdi(sdi), .miso(miso));
    spi_crc_frame_slave uut (.clk(clk), .resetn(resetn), .sclk(sclk), .csN(csN), .sdi(sdi),
        .sdo(sdo), .sdoOe(sdoOe), .reqOut(reqOut), .reqValid(reqValid), .rdAddr(rdAddr),
        .rdActive(rdActive), .rdData(rdData), .faultIn(faultIn),
        .faultRegRead(faultRegRead), .excRecorded(excRecorded));
    function automatic logic [31:0] mk(input logic w, input logic [6:0] a, input logic [19:0] d);
        logic [31:0] f;
        f = {w, a, 1'b0, d, 3'h0};
        return {f[31:3], m.crc3(f)};
    endfunction
    task automatic t_write;
        int v;
        v = nValid;
        m.xfer(mk(1'b1, 7'h15, 20'hABCDE), 32, rx);
        `CHK(nValid, v + 1)
        `CHK(reqOut, {1'b1, 7'h15, 20'hABCDE})
        `CHK(rx[31:3], 29'h0)
        `CHK(rx[2:0], m.crc3(rx))
    endtask
    task automatic t_read;
        @(negedge clk) rdData = 20'h5A5A5;
        m.xfer(mk(1'b0, 7'h2C, 20'h0), 32, rx);
        `CHK(rx[22:3], 20'h5A5A5)
        `CHK(rdAddr, 7'h2C)
        `CHK(reqOut.write, 1'b0)
        `CHK(rx[2:0], m.crc3(rx))
    endtask
    task automatic t_errors;
        logic [31:0] f;
        logic [2:0]  ex;
        int v;
        int len[4] = '{32, 31, 33, 32};
        for (int k = 0; k < 4; k++) begin
            f = mk(1'b1, 7'h10, 20'h12345);
            if (k == 0) f[0] = ~f[0];
            if (k == 3) f[23] = 1'b1;
            if (k == 3) f[2:0] = m.crc3(f);
            // crc is held against the last three bits that arrived
            ex = {k == 1, k == 2, k == 0};
            if (k == 1) ex[0] = f[2:0] != f[3:1];
            if (k == 2) ex[0] = f[2:0] != {f[1:0], 1'b0};
            v = nValid;
            m.xfer(f, len[k], rx);
            `CHK(nValid, v)
            `CHK(rx[31:29], 3'h0)
            m.xfer(mk(1'b0, 7'h10, 20'h0), 32, rx);
            `CHK(rx[31:29], ex)
        end
    endtask
    task automatic t_faults;
        logic [31:0] f;
        @(negedge clk) faultIn = 6'h02;
        repeat (3) @(negedge clk);
        `CHK(excRecorded, 6'h02)
        faultIn = 6'h00;
        faultRegRead = 6'h02;
        f = mk(1'b0, 7'h11, 20'h0);
        f[0] = ~f[0];
        m.xfer(f, 32, rx);
        `CHK(excRecorded, 6'h02)
        m.xfer(mk(1'b0, 7'h11, 20'h0), 32, rx);
        `CHK(rx[28:23], 6'h02)
        `CHK(excRecorded, 6'h00)
        fork
            m.xfer(mk(1'b0, 7'h11, 20'h0), 32, rx);
            begin
                #15000 @(negedge clk) faultIn = 6'h02;
                #5000 `CHK(excRecorded[1], 1'b0)
            end
        join
        `CHK(excRecorded[1], 1'b1)
    endtask
    task complete_run;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        rdData = 20'h0;
        faultIn = 6'h00;
        faultRegRead = 6'h00;
        repeat (20) @(negedge clk);
        `CHK(sdoOe, 1'b0)
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        t_read;
        t_write;
        t_errors;
        t_faults;
        complete_run;
    end
    initial begin
        #1000000;
        n_fail++;
        complete_run;
    end
endmodule
